// ---- ccdfe_ctrl_model.sv ----
// Behavioural camera controller driving the front-end's serial and timing pins
`timescale 1ns/1ns
module ccdfe_ctrl_model
  import ccdfe_pkg::*;
(
  input  wire logic ref_clk,
  output logic      sdata,
  output logic      sclk,
  output logic      wstrobe,
  output logic      ref_b,
  output logic      dat_b,
  output logic      dummy_b,
  output logic      black_b,
  output logic      latch
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    sdata   = 1'b0;
    sclk    = 1'b0;
    wstrobe = 1'b0;
    {ref_b, dat_b, dummy_b, black_b} = 4'hF;
    latch   = 1'b0;
  end

  // One bit as a low-high-low pulse, 80 ns period, data stable around the rise
  task automatic send_bit(input logic b);
    sdata = b;
    repeat (5) @(negedge ref_clk);
    sclk = 1'b1;
    repeat (5) @(negedge ref_clk);
    sclk = 1'b0;
  endtask

  // Whole word: start bit, target bit, ten data bits MSB first
  task automatic send_word(input logic [CCDFE_WORD_W-1:0] w);
    for (int i = CCDFE_WORD_W - 1; i >= 0; i--) begin
      send_bit(w[i]);
    end
    repeat (1) @(negedge ref_clk);
    sdata = ~w[0]; // Released line: no pull, so show the inverse
  endtask

  // Strobe only after the last bit has settled
  task automatic write_pulse();
    repeat (4) @(negedge ref_clk);
    wstrobe = 1'b1;
    repeat (3) @(negedge ref_clk);
    wstrobe = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask

  // Active-low strobes {ref, data, dummy, black}
  task automatic set_strobes(input logic [3:0] s_b);
    {ref_b, dat_b, dummy_b, black_b} = s_b;
    @(negedge ref_clk);
  endtask

  // Output latch clock pulse collects the converted word
  task automatic latch_pulse();
    latch = 1'b1;
    repeat (3) @(negedge ref_clk);
    latch = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
endmodule // ccdfe_ctrl_model

// ---- ccdfe_pkg.sv ----
// Shared constants and carrier types for the camera front-end control block
package ccdfe_pkg;
  // ----------------------------------------------------------------
  // Widths and serial word layout
  // ----------------------------------------------------------------
  localparam int CCDFE_CODE_W   = 10;
  localparam int CCDFE_WORD_W   = 12;
  localparam int CCDFE_START_B  = 11; // Start bit, value ignored
  localparam int CCDFE_TARGET_B = 10; // Low: gain, high: general purpose
  localparam int CCDFE_MV_W     = 12;
  localparam int CCDFE_OFS_W    = 8;
  localparam int CCDFE_SUM_W    = 12;
  localparam int CCDFE_PROD_W   = 22;

  // ----------------------------------------------------------------
  // Reset values and analogue scale
  // ----------------------------------------------------------------
  localparam logic [CCDFE_CODE_W-1:0] CCDFE_CODE_RST = 10'h000;
  localparam logic [CCDFE_WORD_W-1:0] CCDFE_WORD_RST = 12'h000;
  localparam logic [CCDFE_OFS_W-1:0]  CCDFE_OFS_RST  = 8'h00;
  localparam logic [CCDFE_OFS_W-1:0]  CCDFE_OFS_ONE  = 8'h01;
  localparam logic [CCDFE_OFS_W-1:0]  CCDFE_OFS_MAX  = 8'h7F;
  localparam logic [CCDFE_OFS_W-1:0]  CCDFE_OFS_MIN  = 8'h80;
  localparam logic [CCDFE_MV_W-1:0]   CCDFE_MV_TOP   = 12'h960; // 2400 mV at code zero
  localparam logic [CCDFE_PROD_W-1:0] CCDFE_MV_SPAN  = 22'h000834; // 2400 - 300 mV
  localparam logic [CCDFE_PROD_W-1:0] CCDFE_CODE_TOP = 22'h0003FF;
  localparam logic [CCDFE_SUM_W-1:0]  CCDFE_SUM_TOP  = 12'h3FF;
  localparam logic [CCDFE_SUM_W-1:0]  CCDFE_BLACK    = 12'h020; // -FS + 32 LSB

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  // Pins from outside the clock domain; strobes already turned active high
  typedef struct packed {
    logic sdata;
    logic sclk;
    logic wstrobe;
    logic ref_smp;
    logic dat_smp;
    logic dummy;
    logic black;
    logic latch;
    logic pdown;
  } ccdfe_pins_t;

  // Serial clock phase, Gray along idle -> high -> idle
  typedef enum logic [1:0] {
    CCDFE_SER_LOW  = 2'b00,
    CCDFE_SER_HIGH = 2'b01
  } ccdfe_ser_t;
endpackage

// ---- ccdfe_top.sv ----
// Serial converter registers, pixel strobe decoding and output latch of the front-end
`timescale 1ns/1ns
module ccdfe_top
  import ccdfe_pkg::*;
#(
  parameter int CODE_W = CCDFE_CODE_W
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  input  wire logic              REG_RESET_B,
  input  wire logic              SERIAL_DATA_IN,
  input  wire logic              SERIAL_CLOCK,
  input  wire logic              WRITE_STROBE,
  input  wire logic              REF_SAMPLE_STROBE_B,
  input  wire logic              DATA_SAMPLE_STROBE_B,
  input  wire logic              DUMMY_CLAMP_STROBE_B,
  input  wire logic              OPTICAL_BLACK_STROBE_B,
  input  wire logic              OUTPUT_LATCH_CLOCK,
  input  wire logic              POWER_DOWN_INPUT,
  input  wire logic [CODE_W-1:0] CONV_RAW,
  output logic [CODE_W-1:0]      GAIN_CONTROL_CONVERTER,
  output logic [CODE_W-1:0]      GENERAL_PURPOSE_CONVERTER,
  output logic [CCDFE_MV_W-1:0]  GAIN_LEVEL_MV,
  output logic [CCDFE_MV_W-1:0]  GP_LEVEL_MV,
  output logic                   REF_HOLD,
  output logic                   DATA_HOLD,
  output logic                   RESAMPLE_HOLD,
  output logic                   INPUT_CLAMP,
  output logic                   AUTOZERO_ACTIVE,
  output logic                   BLACK_LOOP_ACTIVE,
  output logic                   ADC_CONVERT,
  output logic [CODE_W-1:0]      DATA_OUT,
  output logic                   POWER_SAVE
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Inverted code to output level in millivolts
  function automatic logic [CCDFE_MV_W-1:0] code_to_mv(input logic [CODE_W-1:0] code);
    logic [CCDFE_PROD_W-1:0] prod;
    prod = CCDFE_PROD_W'(code) * CCDFE_MV_SPAN;
    return CCDFE_MV_TOP - CCDFE_MV_W'(prod / CCDFE_CODE_TOP);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ccdfe_pins_t pins_raw;
  ccdfe_pins_t pins_s1;
  ccdfe_pins_t pins_s2;
  ccdfe_pins_t pins_d;
  logic        reg_rst_b;

  // Register reset joins the system reset as a pure reset net
  assign reg_rst_b = RST_B & REG_RESET_B;

  // Active-low strobes are flipped here so the rest reads active high
  assign pins_raw = '{sdata:   SERIAL_DATA_IN,
                      sclk:    SERIAL_CLOCK,
                      wstrobe: WRITE_STROBE,
                      ref_smp: ~REF_SAMPLE_STROBE_B,
                      dat_smp: ~DATA_SAMPLE_STROBE_B,
                      dummy:   ~DUMMY_CLAMP_STROBE_B,
                      black:   ~OPTICAL_BLACK_STROBE_B,
                      latch:   OUTPUT_LATCH_CLOCK,
                      pdown:   POWER_DOWN_INPUT};

  // Two stages, then one more for edge finding; data and clock share
  // the same delay, so their alignment at the pins is preserved
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      pins_d  <= '0;
    end else begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
      pins_d  <= pins_s2;
    end
  end

  logic ws_rise;
  logic dat_rise;
  logic ref_rise;
  logic latch_rise;

  assign ws_rise    = pins_s2.wstrobe & ~pins_d.wstrobe;
  assign dat_rise   = pins_s2.dat_smp & ~pins_d.dat_smp;
  assign ref_rise   = pins_s2.ref_smp & ~pins_d.ref_smp;
  assign latch_rise = pins_s2.latch & ~pins_d.latch;

  // ----------------------------------------------------------------
  // Serial shift register
  // ----------------------------------------------------------------
  ccdfe_ser_t              ser_state;
  logic                    master;
  logic [CCDFE_WORD_W-1:0] shift;
  logic                    ser_rise;
  logic                    ser_fall;

  assign ser_rise = (ser_state == CCDFE_SER_LOW) & pins_s2.sclk;
  assign ser_fall = (ser_state == CCDFE_SER_HIGH) & ~pins_s2.sclk;

  // Phase tracker; a clock parked high simply holds the master
  always_ff @(posedge REF_CLK or negedge reg_rst_b) begin
    if (!reg_rst_b) begin
      ser_state <= CCDFE_SER_LOW;
    end else begin
      case (ser_state)
        CCDFE_SER_LOW:  if (ser_rise) ser_state <= CCDFE_SER_HIGH;
        CCDFE_SER_HIGH: if (ser_fall) ser_state <= CCDFE_SER_LOW;
        default:        ser_state <= CCDFE_SER_LOW;
      endcase
    end
  end

  // Master stage captures on the rising edge
  always_ff @(posedge REF_CLK or negedge reg_rst_b) begin
    if (!reg_rst_b) begin
      master <= 1'b0;
    end else if (ser_rise) begin
      master <= pins_s2.sdata;
    end
  end

  // Slave stage moves on the falling edge; oldest bit falls off the top
  always_ff @(posedge REF_CLK or negedge reg_rst_b) begin
    if (!reg_rst_b) begin
      shift <= CCDFE_WORD_RST;
    end else if (ser_fall) begin
      shift <= {shift[CCDFE_WORD_W-2:0], master};
    end
  end

  // ----------------------------------------------------------------
  // Converter registers
  // ----------------------------------------------------------------
  // Start bit shift[11] is never read
  always_ff @(posedge REF_CLK or negedge reg_rst_b) begin
    if (!reg_rst_b) begin
      GAIN_CONTROL_CONVERTER    <= CCDFE_CODE_RST;
      GENERAL_PURPOSE_CONVERTER <= CCDFE_CODE_RST;
    end else if (ws_rise) begin
      if (shift[CCDFE_TARGET_B]) begin
        GENERAL_PURPOSE_CONVERTER <= shift[CODE_W-1:0];
      end else begin
        GAIN_CONTROL_CONVERTER    <= shift[CODE_W-1:0];
      end
    end
  end

  // Levels; reset leaves both at the top, i.e. maximum gain
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      GAIN_LEVEL_MV <= CCDFE_MV_TOP;
      GP_LEVEL_MV   <= CCDFE_MV_TOP;
    end else begin
      GAIN_LEVEL_MV <= code_to_mv(GAIN_CONTROL_CONVERTER);
      GP_LEVEL_MV   <= code_to_mv(GENERAL_PURPOSE_CONVERTER);
    end
  end

  // ----------------------------------------------------------------
  // Pixel and line strobes
  // ----------------------------------------------------------------
  // Hold pulses last one cycle per strobe assertion
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      REF_HOLD          <= 1'b0;
      DATA_HOLD         <= 1'b0;
      RESAMPLE_HOLD     <= 1'b0;
      INPUT_CLAMP       <= 1'b0;
      AUTOZERO_ACTIVE   <= 1'b0;
      BLACK_LOOP_ACTIVE <= 1'b0;
    end else begin
      REF_HOLD          <= ref_rise;
      DATA_HOLD         <= dat_rise;
      RESAMPLE_HOLD     <= dat_rise;
      INPUT_CLAMP       <= pins_s2.dummy & pins_s2.ref_smp;
      AUTOZERO_ACTIVE   <= pins_s2.dummy;
      BLACK_LOOP_ACTIVE <= pins_s2.black;
    end
  end

  // ----------------------------------------------------------------
  // Black-level loop and conversion path
  // ----------------------------------------------------------------
  logic [CCDFE_OFS_W-1:0]  offset;
  logic [CCDFE_SUM_W-1:0]  sum;
  logic [CODE_W-1:0]       corrected;
  logic [CODE_W-1:0]       conv_word;

  // Signed offset added to the raw code, result clamped to code range
  always_comb begin
    sum = CCDFE_SUM_W'(CONV_RAW) + {{(CCDFE_SUM_W-CCDFE_OFS_W){offset[CCDFE_OFS_W-1]}}, offset};
    if (sum[CCDFE_SUM_W-1]) begin
      corrected = '0;
    end else if (sum > CCDFE_SUM_TOP) begin
      corrected = '1;
    end else begin
      corrected = sum[CODE_W-1:0];
    end
  end

  // One step per pixel while the black strobe is active; a slow loop
  // by design so that noise on one pixel barely moves the level
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      offset <= CCDFE_OFS_RST;
    end else if (pins_s2.black && dat_rise) begin
      if (CCDFE_SUM_W'(corrected) > CCDFE_BLACK && offset != CCDFE_OFS_MIN) begin
        offset <= offset - CCDFE_OFS_ONE;
      end else if (CCDFE_SUM_W'(corrected) < CCDFE_BLACK && offset != CCDFE_OFS_MAX) begin
        offset <= offset + CCDFE_OFS_ONE;
      end
    end
  end

  // Conversion taken on the data strobe, handed out on the latch clock
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      conv_word   <= CCDFE_CODE_RST;
      ADC_CONVERT <= 1'b0;
    end else begin
      ADC_CONVERT <= dat_rise;
      if (dat_rise) begin
        conv_word <= corrected;
      end
    end
  end

  // Output latch; power-down overrides every cycle
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DATA_OUT   <= CCDFE_CODE_RST;
      POWER_SAVE <= 1'b0;
    end else begin
      POWER_SAVE <= pins_s2.pdown;
      if (pins_s2.pdown) begin
        DATA_OUT <= CCDFE_CODE_RST;
      end else if (latch_rise) begin
        DATA_OUT <= conv_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_master_rise: assert property (@(posedge REF_CLK) disable iff (!reg_rst_b)
    ser_rise |=> master == $past(pins_s2.sdata))
    else $error("Master missed data on rise");

  a_shift_fall: assert property (@(posedge REF_CLK) disable iff (!reg_rst_b)
    ser_fall |=> shift == {$past(shift[CCDFE_WORD_W-2:0]), $past(master)})
    else $error("Shift wrong on fall");

  a_shift_hold: assert property (@(posedge REF_CLK) disable iff (!reg_rst_b)
    !ser_fall |=> $stable(shift))
    else $error("Shift moved without fall");

  a_write_gain: assert property (@(posedge REF_CLK) disable iff (!reg_rst_b)
    ws_rise && !shift[CCDFE_TARGET_B] |=> GAIN_CONTROL_CONVERTER == $past(shift[CODE_W-1:0])
      && $stable(GENERAL_PURPOSE_CONVERTER))
    else $error("Gain write wrong");

  a_write_gp: assert property (@(posedge REF_CLK) disable iff (!reg_rst_b)
    ws_rise && shift[CCDFE_TARGET_B] |=> GENERAL_PURPOSE_CONVERTER == $past(shift[CODE_W-1:0])
      && $stable(GAIN_CONTROL_CONVERTER))
    else $error("General purpose write wrong");

  a_reg_reset: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !REG_RESET_B |-> GAIN_CONTROL_CONVERTER == CCDFE_CODE_RST
      && GENERAL_PURPOSE_CONVERTER == CCDFE_CODE_RST && shift == CCDFE_WORD_RST)
    else $error("Register reset did not clear");

  a_level_top: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    GAIN_CONTROL_CONVERTER == CCDFE_CODE_RST |=> GAIN_LEVEL_MV == CCDFE_MV_TOP)
    else $error("Code zero not at top level");

  a_clamp_pair: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    INPUT_CLAMP |-> $past(pins_s2.dummy) && $past(pins_s2.ref_smp))
    else $error("Clamp without both strobes");

  a_hold_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    dat_rise |=> DATA_HOLD && RESAMPLE_HOLD ##1 !DATA_HOLD)
    else $error("Data hold pulse wrong");

  a_black_step: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    pins_s2.black && dat_rise && CCDFE_SUM_W'(corrected) < CCDFE_BLACK
      && offset != CCDFE_OFS_MAX |=> offset == $past(offset) + CCDFE_OFS_ONE)
    else $error("Black loop did not step up");

  a_latch_out: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    latch_rise && !pins_s2.pdown |=> DATA_OUT == $past(conv_word))
    else $error("Latch clock did not present word");

  a_pd_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    pins_s2.pdown |=> DATA_OUT == CCDFE_CODE_RST && POWER_SAVE)
    else $error("Power-down output not zero");

endmodule // ccdfe_top

// ---- test_ccd_frontend_serial_dac_ctrl.sv ----
// Self-checking bench for the camera front-end control block
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module test_ccd_frontend_serial_dac_ctrl;
  import ccdfe_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        ref_clk, rst_b, reg_reset_b, pdown;
  logic        sdata, sclk, wstrobe, ref_b, dat_b, dummy_b, black_b, latch;
  logic [9:0]  conv_raw, gain, gp, data_out;
  logic [11:0] gain_mv, gp_mv;
  logic        ref_hold, data_hold, resample, clamp, autozero, black_act, adc_conv, psave;
  int          errors, samples_checked;

  // Clock, 8 ns period
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  ccdfe_ctrl_model ctrl (.ref_clk(ref_clk), .sdata(sdata), .sclk(sclk), .wstrobe(wstrobe),
    .ref_b(ref_b), .dat_b(dat_b), .dummy_b(dummy_b), .black_b(black_b), .latch(latch));

  ccdfe_top DUT (.REF_CLK(ref_clk), .RST_B(rst_b), .REG_RESET_B(reg_reset_b),
    .SERIAL_DATA_IN(sdata), .SERIAL_CLOCK(sclk), .WRITE_STROBE(wstrobe),
    .REF_SAMPLE_STROBE_B(ref_b), .DATA_SAMPLE_STROBE_B(dat_b),
    .DUMMY_CLAMP_STROBE_B(dummy_b), .OPTICAL_BLACK_STROBE_B(black_b),
    .OUTPUT_LATCH_CLOCK(latch), .POWER_DOWN_INPUT(pdown), .CONV_RAW(conv_raw),
    .GAIN_CONTROL_CONVERTER(gain), .GENERAL_PURPOSE_CONVERTER(gp), .GAIN_LEVEL_MV(gain_mv),
    .GP_LEVEL_MV(gp_mv), .REF_HOLD(ref_hold), .DATA_HOLD(data_hold),
    .RESAMPLE_HOLD(resample), .INPUT_CLAMP(clamp), .AUTOZERO_ACTIVE(autozero),
    .BLACK_LOOP_ACTIVE(black_act), .ADC_CONVERT(adc_conv), .DATA_OUT(data_out),
    .POWER_SAVE(psave));

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Settle time after pins propagate through the synchronisers
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Reset values of converter codes, gain level and strobe outputs
  task automatic sc_reset_values();
    `CHK(gain, 10'h000)
    `CHK(gp, 10'h000)
    `CHK(gain_mv, 12'h960)
    `CHK({ref_hold, data_hold, clamp, black_act, data_out}, 14'h0000)
  endtask

  // Full gain word with start bit high; other converter keeps zero
  task automatic sc_gain_write();
    ctrl.send_word(12'hBFF);
    ctrl.write_pulse();
    settle(4);
    `CHK(gain, 10'h3FF)
    `CHK(gp, 10'h000)
    `CHK(gain_mv, 12'h12C)
  endtask

  // Two stray leading bits, then a general purpose word; only last twelve count
  task automatic sc_gp_long_word();
    ctrl.send_bit(1'b1);
    ctrl.send_bit(1'b1);
    ctrl.send_word(12'h555);
    ctrl.write_pulse();
    settle(4);
    `CHK(gp, 10'h155)
    `CHK(gain, 10'h3FF)
    `CHK(gp_mv, 12'h6A4)
  endtask

  // Register reset pin clears both converter codes while low
  task automatic sc_reg_reset();
    reg_reset_b = 1'b0;
    settle(3);
    `CHK({gain, gp}, 20'h00000)
    reg_reset_b = 1'b1;
    settle(3);
    `CHK(gain_mv, 12'h960)
  endtask

  // Data and reference strobes pulse holds for one cycle; clamps follow levels
  task automatic sc_pixel_strobes();
    ctrl.set_strobes(4'hB);
    settle(2);
    `CHK({data_hold, resample, adc_conv}, 3'h7)
    settle(1);
    `CHK({data_hold, resample, adc_conv}, 3'h0)
    ctrl.set_strobes(4'h5);
    settle(2);
    `CHK({ref_hold, clamp, autozero, black_act}, 4'hE)
    settle(1);
    `CHK({ref_hold, clamp}, 2'h1)
    ctrl.set_strobes(4'hE);
    settle(4);
    `CHK({clamp, autozero, black_act}, 3'h1)
  endtask

  // Black loop pulls a zero input up to 32; power-down forces zero output
  task automatic sc_black_and_power();
    conv_raw = 10'h000;
    for (int i = 0; i < 40; i++) begin
      ctrl.set_strobes(4'hA);
      settle(3);
      ctrl.set_strobes(4'hE);
      settle(3);
    end
    ctrl.set_strobes(4'hF);
    ctrl.latch_pulse();
    `CHK(data_out, 10'h020)
    pdown = 1'b1;
    settle(5);
    `CHK({psave, data_out}, 11'h400)
    pdown = 1'b0;
    settle(5);
    `CHK(psave, 1'b0)
  endtask

  // Raw code plus the settled black offset of 32, clamped at full scale
  task automatic sc_convert_word(input logic [9:0] raw, input logic [9:0] exp);
    conv_raw = raw;
    ctrl.set_strobes(4'hB);
    ctrl.set_strobes(4'hF);
    ctrl.latch_pulse();
    `CHK(data_out, exp)
  endtask

  // Main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    reg_reset_b = 1'b1;
    pdown = 1'b0;
    conv_raw = 10'h000;
    settle(2);
    rst_b = 1'b1;
    settle(4);
    sc_reset_values();
    sc_gain_write();
    sc_gp_long_word();
    sc_reg_reset();
    sc_pixel_strobes();
    sc_black_and_power();
    sc_convert_word(10'h100, 10'h120);
    sc_convert_word(10'h3F0, 10'h3FF);
    tally_and_finish();
  end

  // Hang guard: far beyond the length of the sequence
  initial begin
    #500000;
    errors++;
    tally_and_finish();
  end
endmodule // test_ccd_frontend_serial_dac_ctrl
